// File: src/lcd_driver_command_decoder.sv
/*
 Command decoder of a multiplexed LCD driver: takes received bytes from the
 serial host port, holds the command settings, sequences chip reset and
 calibration reload, and steers the clock pin. Assumes the serial port hands
 over whole bytes as one-cycle strobes on ref_clk; the reset pin arrives async.
*/
`timescale 1ns/10ps
`include "lcd_cmd_cfg.svh"
module lcd_driver_command_decoder
    import lcd_cmd_pkg::*;
#(
    parameter int CAL_LEN = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Received bytes
    input wire logic byte_valid,
    input wire logic byte_kind_select,
    input wire logic [7:0] byte_data,
    // Clock pin (three signals)
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe,
    // Internal oscillator
    input wire logic int_osc,
    // Status and control outputs
    output settings_t settings,
    output logic ram_data_valid,
    output logic [7:0] ram_data,
    output logic chip_reset_busy,
    output logic cal_reload_busy,
    output logic int_osc_run,
    output logic sel_clk,
    output logic outputs_grounded
);
    localparam settings_t DEFAULTS = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
                                       `DEF_MUX_MODE};
    localparam int INIT_N = (`INIT_CYCLES < 1) ? 1 : `INIT_CYCLES;

    settings_t set_q;
    ctl_state_t st_q;
    logic [7:0] cnt_q;
    logic rst_s1_q, rst_s2_q;
    logic ext_s1_q, ext_s2_q;
    logic osc_s1_q, osc_s2_q;
    logic cmd_stb;
    logic is_init, is_cal;

    // Six-bit opcode groups are matched in several places
    function automatic logic hi6_is(input logic [7:0] b, input logic [5:0] op);
        return b[7:2] == op;
    endfunction

    // Reset pin and clock pin both come from outside ref_clk
    always_ff @(posedge ref_clk) begin
        rst_s1_q <= nrst;
        rst_s2_q <= rst_s1_q;
        ext_s1_q <= clk_pin_i;
        ext_s2_q <= ext_s1_q;
        osc_s1_q <= int_osc;
        osc_s2_q <= osc_s1_q;
    end

    assign cmd_stb = byte_valid && !byte_kind_select;
    assign is_init = cmd_stb && (byte_data == `OP_INIT);
    assign is_cal = cmd_stb && (byte_data == `OP_CAL_RELOAD);

    // Settings; initialize and the reset pin restore the same defaults
    always_ff @(posedge ref_clk) begin
        if (!nrst || !rst_s2_q) begin
            set_q <= DEFAULTS;
        end else if (is_init) begin
            set_q <= DEFAULTS;
        end else if (cmd_stb && st_q != ST_INIT) begin
            if (hi6_is(byte_data, `OP_OSC_HI)) begin
                set_q.clk_pin_out_enable <= byte_data[1];
                set_q.osc_source_select <= byte_data[0];
            end else if (hi6_is(byte_data, `OP_PUMP_HI)) begin
                set_q.pump_enable <= byte_data[1];
                set_q.pump_multiplier_select <= byte_data[0];
            end else if (hi6_is(byte_data, `OP_TEMP_HI)) begin
                set_q.temp_comp_enable <= byte_data[1];
                set_q.temp_measure_enable <= byte_data[0];
            end else if (byte_data[7:1] == `OP_DISP_HI) begin
                set_q.display_enable <= byte_data[0];
            end else if (byte_data[7:3] == `OP_MUX_HI) begin
                set_q.mux_mode <= byte_data[2:0];
            end
        end
    end

    // Reset and reload sequencer; setting commands are ignored while in ST_INIT
    always_ff @(posedge ref_clk) begin
        if (!nrst || !rst_s2_q) begin
            st_q <= ST_CAL;
            cnt_q <= `CAL_CYCLES;
        end else if (is_init) begin
            st_q <= ST_INIT;
            cnt_q <= 8'(INIT_N);
        end else if (is_cal) begin
            st_q <= ST_CAL;
            cnt_q <= 8'(CAL_LEN);
        end else begin
            case (st_q)
                ST_INIT: begin
                    if (cnt_q <= 8'h01) begin
                        st_q <= ST_CAL;
                        cnt_q <= 8'(CAL_LEN);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_CAL: begin
                    if (cnt_q <= 8'h01) begin
                        st_q <= ST_IDLE;
                        cnt_q <= 8'h00;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    cnt_q <= 8'h00;
                end
            endcase
        end
    end

    // RAM data path registers data bytes, one cycle after their strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ram_data_valid <= 1'b0;
            ram_data <= 8'h00;
        end else begin
            ram_data_valid <= byte_valid && byte_kind_select;
            // Only a valid data byte may load, idle bus levels are not data
            ram_data <= (byte_valid && byte_kind_select) ? byte_data : ram_data;
        end
    end

    // Clock selection; frame timing downstream counts edges of sel_clk
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_clk <= 1'b0;
            clk_pin_o <= 1'b0;
            clk_pin_oe <= 1'b0;
        end else begin
            sel_clk <= set_q.osc_source_select ? ext_s2_q : osc_s2_q;
            clk_pin_o <= osc_s2_q;
            clk_pin_oe <= set_q.clk_pin_out_enable && !set_q.osc_source_select;
        end
    end

    assign settings = set_q;
    assign chip_reset_busy = (st_q == ST_INIT);
    assign cal_reload_busy = (st_q == ST_CAL);
    assign int_osc_run = !set_q.osc_source_select || set_q.pump_enable;
    assign outputs_grounded = !set_q.display_enable;

    property p_init_defaults;
        @(posedge ref_clk) disable iff (!nrst)
        is_init |=> (set_q == DEFAULTS);
    endproperty
    a_init_defaults: assert property (p_init_defaults) else $error("init no defaults");

    property p_init_short;
        @(posedge ref_clk) disable iff (!nrst)
        is_init |=> ##[0:3] !chip_reset_busy;
    endproperty
    a_init_short: assert property (p_init_short) else $error("init reset too long");

    property p_init_then_cal;
        @(posedge ref_clk) disable iff (!nrst)
        $fell(chip_reset_busy) && !is_init |-> cal_reload_busy;
    endproperty
    a_init_then_cal: assert property (p_init_then_cal) else $error("no reload after init");

    property p_osc_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb && !is_init && byte_data[7:2] == `OP_OSC_HI && !chip_reset_busy
        |=> set_q.clk_pin_out_enable == $past(byte_data[1])
            && set_q.osc_source_select == $past(byte_data[0]);
    endproperty
    a_osc_cmd: assert property (p_osc_cmd) else $error("osc control wrong");

    property p_pin_release;
        @(posedge ref_clk) disable iff (!nrst)
        !set_q.clk_pin_out_enable |=> !clk_pin_oe;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("clk pin driven");

    property p_pump_osc;
        @(posedge ref_clk) disable iff (!nrst)
        set_q.pump_enable |-> int_osc_run;
    endproperty
    a_pump_osc: assert property (p_pump_osc) else $error("pump without osc");

    property p_pump_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb && !is_init && byte_data[7:2] == `OP_PUMP_HI && !chip_reset_busy
        |=> set_q.pump_enable == $past(byte_data[1])
            && set_q.pump_multiplier_select == $past(byte_data[0]);
    endproperty
    a_pump_cmd: assert property (p_pump_cmd) else $error("pump control wrong");

    property p_data_kind;
        @(posedge ref_clk) disable iff (!nrst)
        byte_valid && byte_kind_select |=> ram_data_valid && $stable(set_q);
    endproperty
    a_data_kind: assert property (p_data_kind) else $error("data byte misused");

    property p_disp;
        @(posedge ref_clk) disable iff (!nrst)
        !set_q.display_enable |-> outputs_grounded;
    endproperty
    a_disp: assert property (p_disp) else $error("display not grounded");

    property p_disp_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb && rst_s2_q && !chip_reset_busy && byte_data[7:1] == `OP_DISP_HI
        |=> set_q.display_enable == $past(byte_data[0]);
    endproperty
    a_disp_cmd: assert property (p_disp_cmd) else $error("display enable wrong");

    property p_temp_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb && rst_s2_q && !chip_reset_busy && byte_data[7:2] == `OP_TEMP_HI
        |=> set_q.temp_comp_enable == $past(byte_data[1])
            && set_q.temp_measure_enable == $past(byte_data[0]);
    endproperty
    a_temp_cmd: assert property (p_temp_cmd) else $error("temp control wrong");

    property p_mux_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb && rst_s2_q && !chip_reset_busy && byte_data[7:3] == `OP_MUX_HI
        |=> set_q.mux_mode == $past(byte_data[2:0]);
    endproperty
    a_mux_cmd: assert property (p_mux_cmd) else $error("mux mode wrong");

    property p_cal_cmd;
        @(posedge ref_clk) disable iff (!nrst)
        is_cal && rst_s2_q |=> cal_reload_busy;
    endproperty
    a_cal_cmd: assert property (p_cal_cmd) else $error("no reload on command");

    property p_sync_reset;
        @(posedge ref_clk) disable iff (!nrst)
        !rst_s2_q |=> (set_q == DEFAULTS) && cal_reload_busy;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("reset no defaults");

    property p_oe_ext;
        @(posedge ref_clk) disable iff (!nrst)
        set_q.osc_source_select |=> !clk_pin_oe;
    endproperty
    a_oe_ext: assert property (p_oe_ext) else $error("clk pin driven as input");

    property p_oe_drive;
        @(posedge ref_clk) disable iff (!nrst)
        set_q.clk_pin_out_enable && !set_q.osc_source_select |=> clk_pin_oe;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("clk pin not driven");

    property p_pin_follow;
        @(posedge ref_clk) disable iff (!nrst)
        clk_pin_oe && $past(nrst) |-> clk_pin_o == $past(osc_s2_q);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("clk pin not internal");

    // Selected clock sample trails the chosen synchronised source by one edge
    property p_sel_src;
        @(posedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> sel_clk == $past(set_q.osc_source_select ? ext_s2_q : osc_s2_q);
    endproperty
    a_sel_src: assert property (p_sel_src) else $error("wrong clock selected");

    property p_ram_data;
        @(posedge ref_clk) disable iff (!nrst)
        byte_valid && byte_kind_select |=> ram_data == $past(byte_data);
    endproperty
    a_ram_data: assert property (p_ram_data) else $error("ram byte wrong");

    property p_cmd_not_ram;
        @(posedge ref_clk) disable iff (!nrst)
        cmd_stb |=> !ram_data_valid;
    endproperty
    a_cmd_not_ram: assert property (p_cmd_not_ram) else $error("command seen as data");

    property p_ram_hold;
        @(posedge ref_clk) disable iff (!nrst)
        !byte_valid |=> $stable(ram_data);
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("ram byte changed idle");

    property p_init_refuse;
        @(posedge ref_clk) disable iff (!nrst)
        chip_reset_busy && cmd_stb && !is_init && rst_s2_q |=> $stable(set_q);
    endproperty
    a_init_refuse: assert property (p_init_refuse) else $error("command during init");

    property p_init_busy;
        @(posedge ref_clk) disable iff (!nrst)
        is_init && rst_s2_q |=> chip_reset_busy;
    endproperty
    a_init_busy: assert property (p_init_busy) else $error("init reset not started");

    // Internal source must keep the oscillator running
    property p_int_src_run;
        @(posedge ref_clk) disable iff (!nrst)
        !set_q.osc_source_select |-> int_osc_run;
    endproperty
    a_int_src_run: assert property (p_int_src_run) else $error("internal osc stopped");
endmodule

// File: src/lcd_cmd_cfg.svh
/*
 Opcodes, field positions, reset values and timing counts for the LCD driver
 command decoder. Assumes a single 25 MHz clock (40 ns period).
*/
// Function
// - Initialize opcode resets every command setting to its default.
// - Host port stays usable after initialize; next command accepted at once. The code ignores setting commands for the 2 cycles of ST_INIT.
// - Initialize reset completes within 100 ns of taking effect.
// - Reload calibration at power-on, any reset, initialize and reload opcode.
// - Upper bits 110011 are oscillator control; bit1 clock out, bit0 source.
// - Clock pin released unless clock-output enable set, then drives internal clock. The code also releases it while source select is 1.
// - Source select 0 uses internal oscillator, 1 uses clock pin as input.
// - Pump enabled starts internal oscillator to clock the pump.
// - Frame timing is derived from the selected clock.
// - Upper bits 110000 are pump control; bit1 enables internal generation.
// - Pump bit0 selects multiplier: 0 doubles, 1 triples drive supply.
// - Display enable 0011100x; 0 grounds outputs, 1 drives display.
// - Upper bits 110010 temperature control; compensation bit1, measure bit0; default 1.
// - Upper bits 00000 select multiplex mode from a three-bit field.
`ifndef LCD_CMD_CFG_SVH
`define LCD_CMD_CFG_SVH
`define OP_INIT 8'h3A
`define OP_CAL_RELOAD 8'hD0
`define OP_OSC_HI 6'h33
`define OP_PUMP_HI 6'h30
`define OP_TEMP_HI 6'h32
`define OP_DISP_HI 7'h1C
`define OP_MUX_HI 5'h00
`define DEF_MUX_MODE 3'h6
`define INIT_TIME_NS 100
`define CLK_PERIOD_NS 40
`define INIT_CYCLES ((`INIT_TIME_NS) / (`CLK_PERIOD_NS))
`define CAL_CYCLES 8'h10
`endif

// File: src/lcd_cmd_pkg.sv
/*
 Types shared by the LCD driver command decoder.
 Assumes the cfg header for all numeric constants.
*/
package lcd_cmd_pkg;
    typedef struct packed {
        logic clk_pin_out_enable;
        logic osc_source_select;
        logic pump_enable;
        logic pump_multiplier_select;
        logic temp_comp_enable;
        logic temp_measure_enable;
        logic display_enable;
        logic [2:0] mux_mode;
    } settings_t;
    typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_CAL} ctl_state_t;
endpackage

// File: sim/host_model.sv
/*
 Host side of the byte port: hands whole bytes to the decoder.
 Assumes the caller enters send and idle just after a falling edge of ref_clk.
*/
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic ref_clk,
    // Byte port toward the decoder
    output logic byte_valid,
    output logic byte_kind_select,
    output logic [7:0] byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_kind_select = 1'b0;
        byte_data = 8'h00;
    end
    // Strobe stays up between back-to-back bytes, so no double edge in one step
    task automatic send(input logic kind, input logic [7:0] data);
        byte_valid = 1'b1;
        byte_kind_select = kind;
        byte_data = data;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // Released lines show the inverse so a stale byte cannot look valid
    task automatic idle();
        byte_valid = 1'b0;
        byte_kind_select = ~byte_kind_select;
        byte_data = ~byte_data;
    endtask
endmodule

// File: sim/lcd_driver_command_decoder_test.sv
/*
 Self-checking bench for the LCD command decoder.
 Assumes host_model drives the byte port; both clock pins toggle freely here.
*/
`timescale 1ns/10ps
module lcd_driver_command_decoder_test;
    import lcd_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic int_osc = 1'b0;
    logic clk_pin_i = 1'b0;
    logic byte_valid, byte_kind_select, clk_pin_o, clk_pin_oe, ram_data_valid;
    logic chip_reset_busy, cal_reload_busy, int_osc_run, sel_clk, outputs_grounded;
    logic [7:0] byte_data, ram_data;
    settings_t settings;
    int error_cnt = 0;
    int total_checks = 0;
    always #20 ref_clk = ~ref_clk;
    always #60 int_osc = ~int_osc;
    // External clock never stops, a stall could freeze the panel
    always #100 clk_pin_i = ~clk_pin_i;
    host_model host (.ref_clk(ref_clk), .byte_valid(byte_valid),
        .byte_kind_select(byte_kind_select), .byte_data(byte_data));
    lcd_driver_command_decoder #(.CAL_LEN(4)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .byte_valid(byte_valid), .byte_kind_select(byte_kind_select), .byte_data(byte_data),
        .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe),
        .int_osc(int_osc), .settings(settings), .ram_data_valid(ram_data_valid),
        .ram_data(ram_data), .chip_reset_busy(chip_reset_busy),
        .cal_reload_busy(cal_reload_busy), .int_osc_run(int_osc_run),
        .sel_clk(sel_clk), .outputs_grounded(outputs_grounded));
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cmd(input logic [7:0] d);
        host.send(1'b0, d);
        host.idle();
        cyc(1);
    endtask
    task automatic wait_cal_done();
        // No power-down is requested while a reload runs
        for (int i = 0; i < 40 && cal_reload_busy !== 1'b0; i++) cyc(1);
        check("cal_done", cal_reload_busy, 10'h000);
    endtask
    task automatic t_defaults();
        for (int i = 0; i < 6 && cal_reload_busy !== 1'b1; i++) cyc(1);
        check("cal_after_reset", cal_reload_busy, 10'h001);
        check("settings_default", settings, 10'h036);
        check("pin_released", clk_pin_oe, 10'h000);
        check("grounded", outputs_grounded, 10'h001);
        wait_cal_done();
    endtask
    task automatic t_osc_pump();
        int flips;
        logic last;
        cmd(8'hCE);
        check("osc_ce", settings, 10'h236);
        cyc(1);
        check("pin_driven", clk_pin_oe, 10'h001);
        check("osc_int_run", int_osc_run, 10'h001);
        last = clk_pin_o;
        flips = 0;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            if (clk_pin_o !== last) flips++;
            last = clk_pin_o;
        end
        check("pin_clock", flips > 0, 10'h001);
        cmd(8'hCD);
        cyc(1);
        check("osc_cd", settings, 10'h136);
        check("pin_input", clk_pin_oe, 10'h000);
        check("osc_ext_run", int_osc_run, 10'h000);
        @(posedge clk_pin_i);
        cyc(4);
        check("sel_ext_high", sel_clk, 10'h001);
        @(negedge clk_pin_i);
        cyc(4);
        check("sel_ext_low", sel_clk, 10'h000);
        cmd(8'hC2);
        check("pump_on", settings, 10'h1B6);
        check("pump_osc_run", int_osc_run, 10'h001);
        cmd(8'hC1);
        check("pump_triple", settings, 10'h176);
    endtask
    task automatic t_display_mux();
        cmd(8'h39);
        check("display_on", outputs_grounded, 10'h000);
        cmd(8'hC9);
        cmd(8'h02);
        check("temp_mux", settings, 10'h15A);
    endtask
    task automatic t_ram_data();
        host.send(1'b1, 8'hA5);
        host.idle();
        for (int i = 0; i < 3 && ram_data_valid !== 1'b1; i++) cyc(1);
        check("ram_valid", ram_data_valid, 10'h001);
        check("ram_byte", ram_data, 10'h0A5);
        check("ram_no_cmd", settings, 10'h15A);
    endtask
    task automatic t_init();
        host.send(1'b0, 8'h3A);
        host.send(1'b0, 8'hCE);
        host.idle();
        cyc(1);
        check("init_refuse", settings, 10'h036);
        cyc(1);
        check("init_done", chip_reset_busy, 10'h000);
        cmd(8'hCE);
        check("after_init", settings, 10'h236);
        check("cal_after_init", cal_reload_busy, 10'h001);
        wait_cal_done();
        cmd(8'hD0);
        check("cal_cmd", cal_reload_busy, 10'h001);
        wait_cal_done();
    endtask
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        cyc(4);
        nrst = 1'b1;
        t_defaults();
        t_osc_pump();
        t_display_mux();
        t_ram_data();
        t_init();
        nrst = 1'b0;
        cyc(4);
        nrst = 1'b1;
        t_defaults();
        close_out();
    end
endmodule
